/* imr_defines.svh */
`ifndef IMR_DEFINES_SVH
`define IMR_DEFINES_SVH

// Byte offsets of the registers
`define IMR_OFF_INT_STATUS 8'h00
`define IMR_OFF_INT_MASK 8'h04
`define IMR_OFF_MISSED 8'h08
`define IMR_OFF_ROM_PORT 8'h0c

// Reset values
`define IMR_RST_INT_MASK 32'hfffe0000
`define IMR_RST_MISSED 32'hfffe0000
`define IMR_RST_ROM_PORT 32'hffff03ff

// Interrupt mask fields
`define IMR_NORMAL_SUM_BIT 16
`define IMR_ABNORMAL_SUM_BIT 15
`define IMR_TX_DONE_BIT 0
`define IMR_TX_HALTED_BIT 1
`define IMR_TX_NO_BUF_BIT 2
`define IMR_JABBER_BIT 3
`define IMR_LINK_GOOD_BIT 4
`define IMR_UNDERFLOW_BIT 5
`define IMR_EVENT_BITS 6

// Missed-frame fields
`define IMR_MISS_OVF_BIT 16
`define IMR_MISS_CNT_BITS 16

// ROM port fields
`define IMR_ROM_MODE_BIT 15
`define IMR_ROM_RD_BIT 14
`define IMR_ROM_WR_BIT 13
`define IMR_ROM_BR_BIT 12
`define IMR_ROM_SR_BIT 11
`define IMR_ROM_EXT_BIT 10
`define IMR_SROM_DO_BIT 3
`define IMR_SROM_DI_BIT 2
`define IMR_SROM_CLK_BIT 1
`define IMR_SROM_CS_BIT 0

// Boot ROM access timing
`define IMR_CLK_PERIOD_NS 25
`define IMR_ROM_ACCESS_NS 150
`define IMR_ROM_ACCESS_CYC ((`IMR_ROM_ACCESS_NS + `IMR_CLK_PERIOD_NS - 1) / `IMR_CLK_PERIOD_NS)

`endif

/* imr_pkg.sv */
`include "imr_defines.svh"

package imr_pkg;

	typedef enum logic [1:0] {
		IMR_ROM_IDLE,
		IMR_ROM_READ,
		IMR_ROM_WRITE
	} imr_rom_state_t;

	// Bit 0 is tx_done, bit 5 underflow, matching the status layout
	typedef struct packed {
		logic underflow;
		logic link_good;
		logic jabber;
		logic tx_no_buffer;
		logic tx_halted;
		logic tx_done;
	} imr_tx_evt_t;

	typedef struct packed {
		logic cs;
		logic clk;
		logic di;
	} imr_srom_out_t;

	typedef struct packed {
		logic sel;
		logic rd;
		logic wr;
		logic [7:0] dout;
		logic doe;
	} imr_brom_out_t;

	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
		logic [5:0] int_st;
		logic [31:0] int_mask;
		logic [15:0] miss_cnt;
		logic miss_ovf;
		logic rom_rd;
		logic rom_wr;
		logic rom_br;
		logic rom_sr;
		logic rom_ext;
		logic [7:0] rom_data;
		imr_rom_state_t rom_state;
		logic [3:0] rom_cnt;
		logic mode_s1;
		logic mode_s2;
		logic sdo_s1;
		logic sdo_s2;
		logic [7:0] bdin_s1;
		logic [7:0] bdin_s2;
		logic irq;
		logic ext_sel;
		imr_srom_out_t srom;
		imr_brom_out_t brom;
	} imr_state_t;

endpackage

/* imr_rom_port.sv */
`timescale 1ns/1ps
`include "imr_defines.svh"

module imr_rom_port (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire imr_pkg::imr_tx_evt_t tx_evt,
	input wire logic frame_missed,
	input wire logic mode_select_pin,
	output logic irq,
	output logic ext_reg_sel,
	output imr_pkg::imr_brom_out_t brom,
	input wire logic [7:0] brom_din,
	output imr_pkg::imr_srom_out_t srom,
	input wire logic srom_dout
);

	localparam logic [3:0] ROM_CYC = 4'(`IMR_ROM_ACCESS_CYC);

	imr_pkg::imr_state_t s;
	imr_pkg::imr_state_t n;

	// reset pattern; the mode bit is not stored, it always reads the inverse of the synchronised pin
	localparam imr_pkg::imr_state_t RST_VAL = '{
		int_mask: `IMR_RST_INT_MASK,
		miss_cnt: 16'(`IMR_RST_MISSED),
		miss_ovf: 1'b0,
		rom_data: 8'(`IMR_RST_ROM_PORT),
		rom_state: imr_pkg::IMR_ROM_IDLE,
		default: '0
	};

	logic take;
	logic hit;
	logic [5:0] clr;
	logic [5:0] post_en;
	logic [16:0] cnt_inc;
	logic sr_mode;
	logic start_rd;
	logic start_wr;
	logic [7:0] rom_rd_data;
	logic [31:0] rd_mux;

	always_comb begin
		n = s;
		take = hsel & htrans[1] & hready;
		hit = (haddr[31:8] == 24'h000000);
		clr = 6'h00;
		start_rd = 1'b0;
		start_wr = 1'b0;
		cnt_inc = 17'h00000;

		// Pins are synchronised before use
		n.mode_s1 = mode_select_pin;
		n.mode_s2 = s.mode_s1;
		n.sdo_s1 = srom_dout;
		n.sdo_s2 = s.sdo_s1;
		n.bdin_s1 = brom_din;
		n.bdin_s2 = s.bdin_s1;

		// In serial mode (sr with rd or wr) bit 3 shows the synchronised serial pin instead of the stored bit
		sr_mode = s.rom_sr & (s.rom_rd | s.rom_wr);
		rom_rd_data = s.rom_data;
		if (sr_mode) begin
			rom_rd_data[`IMR_SROM_DO_BIT] = s.sdo_s2;
		end

		case (haddr[7:0])
			`IMR_OFF_INT_STATUS: begin
				rd_mux = {26'h0000000, s.int_st};
			end
			`IMR_OFF_INT_MASK: begin
				rd_mux = s.int_mask;
			end
			`IMR_OFF_MISSED: begin
				rd_mux = {15'h7fff, s.miss_ovf, s.miss_cnt};
			end
			`IMR_OFF_ROM_PORT: begin
				rd_mux = {16'hffff, ~s.mode_s2, s.rom_rd, s.rom_wr, s.rom_br, s.rom_sr, s.rom_ext, 2'b11, rom_rd_data};
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
		if (!hit) begin
			rd_mux = 32'h00000000;
		end

		// Address phase: read data is captured now so hrdata is a flop
		n.wr_pend = take & hwrite & hit;
		if (take) begin
			n.wr_addr = haddr[7:0];
		end
		if (take && !hwrite) begin
			n.hrdata = rd_mux;
		end

		// count drops, zero on read; a miss in the read cycle still counts
		cnt_inc = {1'b0, s.miss_cnt} + 17'h00001;
		if (take && !hwrite && hit && haddr[7:0] == `IMR_OFF_MISSED) begin
			n.miss_cnt = frame_missed ? 16'h0001 : 16'h0000;
			n.miss_ovf = 1'b0;
		end else if (frame_missed) begin
			n.miss_cnt = cnt_inc[15:0];
			if (cnt_inc[16]) begin
				n.miss_ovf = 1'b1;
			end
		end

		// Data phase of a write
		if (s.wr_pend) begin
			case (s.wr_addr)
				`IMR_OFF_INT_STATUS: begin
					clr = hwdata[5:0];
				end
				`IMR_OFF_INT_MASK: begin
					n.int_mask = hwdata;
				end
				`IMR_OFF_ROM_PORT: begin
					n.rom_rd = hwdata[`IMR_ROM_RD_BIT];
					n.rom_wr = hwdata[`IMR_ROM_WR_BIT];
					n.rom_br = hwdata[`IMR_ROM_BR_BIT];
					n.rom_sr = hwdata[`IMR_ROM_SR_BIT];
					n.rom_ext = hwdata[`IMR_ROM_EXT_BIT];
					n.rom_data = hwdata[7:0];
					start_rd = hwdata[`IMR_ROM_BR_BIT] & hwdata[`IMR_ROM_RD_BIT];
					start_wr = hwdata[`IMR_ROM_BR_BIT] & hwdata[`IMR_ROM_WR_BIT] & ~start_rd;
				end
				default: begin
					clr = 6'h00;
				end
			endcase
		end

		// Sticky status: a new event beats a clear in the same cycle
		n.int_st = (s.int_st & ~clr) | tx_evt;

		// Boot ROM access sequencer; a new start while busy is dropped
		case (s.rom_state)
			imr_pkg::IMR_ROM_IDLE: begin
				if (start_rd) begin
					n.rom_state = imr_pkg::IMR_ROM_READ;
					n.rom_cnt = ROM_CYC - 4'h1;
				end else if (start_wr) begin
					n.rom_state = imr_pkg::IMR_ROM_WRITE;
					n.rom_cnt = ROM_CYC - 4'h1;
				end
			end
			imr_pkg::IMR_ROM_READ: begin
				if (s.rom_cnt == 4'h0) begin
					n.rom_state = imr_pkg::IMR_ROM_IDLE;
					// returned byte lands in data field
					n.rom_data = s.bdin_s2;
				end else begin
					n.rom_cnt = s.rom_cnt - 4'h1;
				end
			end
			imr_pkg::IMR_ROM_WRITE: begin
				if (s.rom_cnt == 4'h0) begin
					n.rom_state = imr_pkg::IMR_ROM_IDLE;
				end else begin
					n.rom_cnt = s.rom_cnt - 4'h1;
				end
			end
			default: begin
				n.rom_state = imr_pkg::IMR_ROM_IDLE;
			end
		endcase

		n.brom.sel = n.rom_br;
		n.brom.rd = (n.rom_state == imr_pkg::IMR_ROM_READ);
		n.brom.wr = (n.rom_state == imr_pkg::IMR_ROM_WRITE);
		n.brom.doe = n.brom.wr;
		n.brom.dout = n.rom_data;

		n.ext_sel = n.rom_ext;

		if (n.rom_sr & (n.rom_rd | n.rom_wr)) begin
			n.srom.di = n.rom_data[`IMR_SROM_DI_BIT];
			n.srom.clk = n.rom_data[`IMR_SROM_CLK_BIT];
			n.srom.cs = n.rom_data[`IMR_SROM_CS_BIT];
		end else begin
			n.srom = '0;
		end

		// Summary masks pick normal or abnormal group per source
		// tx done
		post_en[`IMR_TX_DONE_BIT] = n.int_mask[`IMR_NORMAL_SUM_BIT];
		post_en[`IMR_TX_HALTED_BIT] = n.int_mask[`IMR_ABNORMAL_SUM_BIT];
		post_en[`IMR_TX_NO_BUF_BIT] = n.int_mask[`IMR_NORMAL_SUM_BIT];
		post_en[`IMR_JABBER_BIT] = n.int_mask[`IMR_ABNORMAL_SUM_BIT];
		post_en[`IMR_LINK_GOOD_BIT] = n.int_mask[`IMR_ABNORMAL_SUM_BIT];
		post_en[`IMR_UNDERFLOW_BIT] = n.int_mask[`IMR_ABNORMAL_SUM_BIT];
		n.irq = |(n.int_st & n.int_mask[5:0] & post_en);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= RST_VAL;
		end else begin
			s <= n;
		end
	end

	// Zero wait states and always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign irq = s.irq;
	assign ext_reg_sel = s.ext_sel;
	assign brom = s.brom;
	assign srom = s.srom;

endmodule

/* imr_rom_port_monitor.sv */
`timescale 1ns/1ps
module imr_rom_port_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire imr_pkg::imr_tx_evt_t tx_evt,
	input wire logic mode_select_pin,
	input wire logic irq,
	input wire logic ext_reg_sel,
	input wire imr_pkg::imr_brom_out_t brom,
	input wire imr_pkg::imr_srom_out_t srom
);
	logic wr_reg;
	logic rd_reg;
	logic [7:0] a_reg;
	logic [3:0] pin_reg;
	wire wr_rom = wr_reg && a_reg == 8'h0c;
	wire rd_rom = rd_reg && a_reg == 8'h0c;
	wire idle = !brom.rd && !brom.wr;
	wire srm = hwdata[11] && |hwdata[14:13];
	// Data-phase view of the bus, plus a pin history to skip synchroniser settling
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			a_reg <= 8'hff;
			pin_reg <= 4'h0;
		end else begin
			wr_reg <= hsel && htrans[1] && hready && hwrite;
			rd_reg <= hsel && htrans[1] && hready && !hwrite;
			a_reg <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
			pin_reg <= {pin_reg[2:0], mode_select_pin};
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_burst;
		brom.rd [*6] ##1 !brom.rd;
	endsequence
	sequence wr_burst;
		(brom.wr && brom.doe) [*6] ##1 !brom.wr;
	endsequence
	AST_ROM_RD:
	assert property (wr_rom && hwdata[12] && hwdata[14] && idle |=> rd_burst) else $error("boot read strobe");
	AST_ROM_WR:
	assert property (wr_rom && hwdata[14:12] == 3'b011 && idle |=> wr_burst) else $error("boot write strobe");
	AST_EXT:
	assert property (wr_rom |=> ext_reg_sel == $past(hwdata[10])) else $error("ext select");
	AST_SROM_PINS:
	assert property (wr_rom && srm |=> srom == $past({hwdata[0], hwdata[1], hwdata[2]})) else $error("serial pins");
	AST_SROM_OFF:
	assert property (wr_rom && !srm |=> srom == 3'b000) else $error("serial pins idle");
	AST_IRQ:
	assert property ($rose(irq) |-> $past(|tx_evt) || $past(wr_reg)) else $error("irq without cause");
	AST_MISS_HI:
	assert property (rd_reg && a_reg == 8'h08 |-> hrdata[31:17] == 15'h7fff) else $error("miss upper bits");
	AST_MODE:
	assert property (rd_rom && pin_reg == {4{mode_select_pin}} |-> hrdata[15] == !mode_select_pin) else $error("mode bit");
	AST_RSVD:
	assert property (rd_rom |-> hrdata[31:16] == 16'hffff && hrdata[9:8] == 2'b11) else $error("rom fixed bits");
	// With both summaries or all event masks cleared nothing may post
	AST_IRQ_OFF:
	assert property (wr_reg && a_reg == 8'h04 && (hwdata[16:15] == 2'b00 || hwdata[5:0] == 6'h00)
		|=> !irq) else $error("irq with mask clear");
endmodule

/* imr_rom_model.sv */
`timescale 1ns/1ps
module imr_rom_model #(
	parameter logic [7:0] ROM_BYTE = 8'ha5,
	parameter logic [7:0] SROM_WORD = 8'hc9
) (
	input wire logic hclk,
	input wire imr_pkg::imr_brom_out_t brom,
	input wire imr_pkg::imr_srom_out_t srom,
	output logic [7:0] brom_din,
	output logic srom_dout,
	output logic [7:0] cap
);
	logic [7:0] last_b = 8'h00;
	logic [7:0] sh = SROM_WORD;
	logic last_s = 1'b0;
	assign brom_din = (brom.sel && brom.rd) ? ROM_BYTE : ~last_b;
	assign srom_dout = srom.cs ? sh[7] : ~last_s;
	// Released lines toggle so a stale value never reads as good
	always @(posedge hclk) begin
		last_b <= brom_din;
		last_s <= srom_dout;
	end
	always @(posedge srom.clk) if (srom.cs) cap <= {cap[6:0], srom.di};
	always @(negedge srom.clk) if (srom.cs) sh <= {sh[6:0], sh[7]};
endmodule

/* imr_rom_port_bench.sv */
`timescale 1ns/1ps
module imr_rom_port_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic frame_missed = 1'b0;
	logic mode_select_pin = 1'b0;
	logic hreadyout, hresp, irq, ext_reg_sel, srom_dout;
	logic [31:0] hrdata, rdat, d;
	logic [7:0] brom_din, cap;
	imr_pkg::imr_tx_evt_t tx_evt = '0;
	imr_pkg::imr_brom_out_t brom;
	imr_pkg::imr_srom_out_t srom;
	int error_cnt = 0;
	int n_tests = 0;
	always #12.5 hclk = ~hclk;
	imr_rom_port DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_evt, .frame_missed, .mode_select_pin,
		.irq, .ext_reg_sel, .brom, .brom_din, .srom, .srom_dout);
	imr_rom_model #(.ROM_BYTE(8'ha5), .SROM_WORD(8'hc9)) PEER (.hclk, .brom, .srom, .brom_din,
		.srom_dout, .cap);
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdat = hrdata;
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task t_reset;
		xfer(0, 8'h04, 0);
		chk("mask", rdat, 32'hfffe0000);
		xfer(0, 8'h08, 0);
		chk("miss", rdat, 32'hfffe0000);
		xfer(0, 8'h0c, 0);
		chk("rom", rdat, 32'hffff83ff);
		chk("resp", 32'(hresp), 0);
		$display("reset test done");
	endtask
	task t_irq;
		logic [31:0] s, b;
		for (int i = 0; i < 6; i++) begin
			b = 32'h1 << i;
			s = (i == 0 || i == 2) ? 32'h10000 : 32'h8000;
			xfer(1, 8'h04, s);
			tx_evt <= b[5:0];
			cyc(1);
			tx_evt <= '0;
			cyc(1);
			chk("irq masked", 32'(irq), 0);
			xfer(0, 8'h00, 0);
			chk("status", rdat, b);
			xfer(1, 8'h04, s | b);
			cyc(2);
			chk("irq on", 32'(irq), 1);
			xfer(1, 8'h04, b);
			cyc(2);
			chk("irq summary", 32'(irq), 0);
			xfer(1, 8'h00, b);
			xfer(1, 8'h04, s | b);
			cyc(2);
			chk("irq cleared", 32'(irq), 0);
		end
		$display("irq test done");
	endtask
	task t_miss;
		frame_missed <= 1'b1;
		cyc(3);
		frame_missed <= 1'b0;
		xfer(0, 8'h08, 0);
		chk("miss 3", rdat, 32'hfffe0003);
		xfer(0, 8'h08, 0);
		chk("miss clr", rdat, 32'hfffe0000);
		frame_missed <= 1'b1;
		cyc(65537);
		frame_missed <= 1'b0;
		xfer(0, 8'h08, 0);
		chk("miss wrap", rdat, 32'hffff0001);
		xfer(0, 8'h08, 0);
		chk("ovf clr", rdat, 32'hfffe0000);
		$display("miss test done");
	endtask
	task t_boot;
		xfer(1, 8'h0c, 32'h5000);
		cyc(10);
		xfer(0, 8'h0c, 0);
		chk("boot read", rdat, 32'hffffd3a5);
		xfer(1, 8'h0c, 32'h305a);
		cyc(1);
		chk("boot dout", 32'(brom.dout), 32'h5a);
		chk("boot wr", 32'(brom.wr), 1);
		chk("boot sel", 32'(brom.sel), 1);
		cyc(6);
		chk("boot wr end", 32'(brom.wr), 0);
		xfer(1, 8'h0c, 32'h0400);
		cyc(1);
		chk("ext", 32'(ext_reg_sel), 1);
		chk("boot sel off", 32'(brom.sel), 0);
		xfer(0, 8'h0c, 0);
		chk("mode kept", rdat, 32'hffff8700);
		mode_select_pin <= 1'b1;
		cyc(4);
		xfer(0, 8'h0c, 0);
		chk("mode 1", rdat, 32'hffff0700);
		$display("boot test done");
	endtask
	task t_serial;
		for (int i = 7; i >= 0; i--) begin
			d = 32'h4801 + (((8'h3c >> i) & 8'h1) != 0 ? 32'h4 : 32'h0);
			xfer(1, 8'h0c, d);
			xfer(1, 8'h0c, d | 32'h2);
			cyc(2);
			xfer(0, 8'h0c, 0);
			chk("srom bit", 32'(rdat[3]), 32'((8'hc9 >> i) & 8'h1));
		end
		chk("srom in", 32'(cap), 32'h3c);
		xfer(1, 8'h0c, 0);
		$display("serial test done");
	endtask
	initial begin
		cyc(3);
		hresetn <= 1'b1;
		cyc(1);
		t_reset;
		t_irq;
		t_miss;
		t_boot;
		t_serial;
		complete_run;
	end
	initial begin
		cyc(100000);
		error_cnt++;
		complete_run;
	end
endmodule
bind imr_rom_port imr_rom_port_monitor MON (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hwdata, .hrdata, .tx_evt, .mode_select_pin, .irq, .ext_reg_sel, .brom, .srom);
